/* fan_commutation.sv */
// Purpose : Single-phase fan commutation: input duty decode, speed curve,
//           soft on/off sequencing, adaptive off interval, rotor lock
// Assumes : One 100 MHz clock; Hall, current-zero and PWM arrive asynchronously
// Notes   : Each bridge leg is a high/low gate pair; both gates of a leg off = Hi-Z
//
// Overview of operation
// R1: Output duty rises linearly with measured input duty
// R2: Decode 2-100kHz input; bridge fixed at 26kHz
// R3: Hall high is south half, low north
// R4: Soft-on ramps first output up, second low
// R5: Soft-on spans 22.5 to 45 degrees
// R6: Normal interval holds target duty, second low
// R7: Soft-off ramps first output down, second low
// R8: Soft-off spans 45 to 22.5 degrees
// R9: Off interval: first Hi-Z, second low, adaptive
// R10: Off length locks Hall fall to current zero
// R11: Hall low swaps conducting output, same sequence
// R12: Start threshold with hysteresis in zero-speed mode
// R13: Running duty comes from nine-entry curve table
// R14: Rotor lock window nominally 0.6 s
// R15: On lock both lows on, then retry
// R16: Zero-speed off keeps table minimum duty
// R17: Interpolate linearly between adjacent table entries
`timescale 1ns/10ps
module fan_commutation #(
    parameter int IN_TIMEOUT_CYCLES = fan_commutation_pkg::IN_TIMEOUT,
    parameter int LOCK_CYCLES       = fan_commutation_pkg::LOCK_TIME_MS * fan_commutation_pkg::CYCLES_PER_MS,
    parameter int RETRY_CYCLES      = fan_commutation_pkg::RETRY_TIME_MS * fan_commutation_pkg::CYCLES_PER_MS,
    parameter int START_HALF_CYCLES = fan_commutation_pkg::START_HALF
) (
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic       i_speed_pwm,
    input  wire logic       i_hall,
    input  wire logic       i_current_zero,
    input  wire logic       i_zero_speed_below_start,
    input  wire logic [7:0] i_start_duty_setting,
    output logic            o_bridge_output_a_high,
    output logic            o_bridge_output_a_low,
    output logic            o_bridge_output_b_high,
    output logic            o_bridge_output_b_low,
    output logic            o_rotor_locked,
    output logic [7:0]      o_input_duty
);
    localparam logic [16:0] TIMEOUT_LAST = 17'(IN_TIMEOUT_CYCLES - 1);
    localparam logic [31:0] LOCK_LAST    = 32'(LOCK_CYCLES - 1);
    localparam logic [31:0] RETRY_LAST   = 32'(RETRY_CYCLES - 1);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic pwm_s1, pwm_s2, pwm_s3;
    logic hall_s1, hall_s2, hall_s3;
    logic cz_s1, cz_s2, cz_s3;

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            {pwm_s1, pwm_s2, pwm_s3}    <= 3'h0;
            {hall_s1, hall_s2, hall_s3} <= 3'h0;
            {cz_s1, cz_s2, cz_s3}       <= 3'h0;
        end
        else
        begin
            {pwm_s1, pwm_s2, pwm_s3}    <= {i_speed_pwm, pwm_s1, pwm_s2};
            {hall_s1, hall_s2, hall_s3} <= {i_hall, hall_s1, hall_s2};
            {cz_s1, cz_s2, cz_s3}       <= {i_current_zero, cz_s1, cz_s2};
        end
    end

    wire pwm_rise  = pwm_s2 & ~pwm_s3;
    wire hall_edge = hall_s2 ^ hall_s3;
    wire hall_fall = ~hall_s2 & hall_s3;
    wire cz_edge   = cz_s2 ^ cz_s3;

    // ----------------------------------------------------------------
    // Input duty measurement, any rate in the 2-100 kHz band
    // ----------------------------------------------------------------
    logic [16:0] per_cnt, hi_cnt, per_lat;
    logic [17:0] rem;
    logic [7:0]  quot, in_duty;
    logic [3:0]  div_left;

    wire         timeout   = (per_cnt == TIMEOUT_LAST);
    wire  [16:0] per_now   = per_cnt + 17'h00001;
    wire  [17:0] rem_dbl   = {rem[16:0], 1'b0};
    wire         rem_ge    = (rem_dbl >= {1'b0, per_lat});
    wire  [17:0] next_rem  = rem_ge ? rem_dbl - {1'b0, per_lat} : rem_dbl;
    wire  [7:0]  next_quot = {quot[6:0], rem_ge};

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            per_cnt <= 17'h00000; hi_cnt <= 17'h00000; per_lat <= 17'h00001;
            rem <= 18'h00000; quot <= 8'h00; in_duty <= 8'h00; div_left <= 4'h0;
        end
        else if (pwm_rise)                                                       // R2
        begin
            per_cnt <= 17'h00000; hi_cnt <= 17'h00001; per_lat <= per_now; // Rise cycle is high
            rem <= {1'b0, hi_cnt}; quot <= 8'h00;
            div_left <= (hi_cnt >= per_now) ? 4'h0 : 4'h8;
            if (hi_cnt >= per_now)
                in_duty <= fan_commutation_pkg::DUTY_FULL;
        end
        else if (timeout)
        begin
            // Static input: a stuck-high pin means full speed
            per_cnt <= 17'h00000; hi_cnt <= 17'h00000; div_left <= 4'h0;
            in_duty <= pwm_s2 ? fan_commutation_pkg::DUTY_FULL : fan_commutation_pkg::DUTY_ZERO;
        end
        else
        begin
            per_cnt <= per_now;
            hi_cnt  <= hi_cnt + {16'h0000, pwm_s2};
            if (div_left != 4'h0)
            begin
                rem <= next_rem; quot <= next_quot; div_left <= div_left - 4'h1;
                if (div_left == 4'h1)
                    in_duty <= next_quot;                                        // R1
            end
        end
    end
    assign o_input_duty = in_duty;

    // ----------------------------------------------------------------
    // Speed curve and start threshold
    // ----------------------------------------------------------------
    wire  [2:0]  lut_idx  = in_duty[7:5];
    wire  [7:0]  lut_lo   = fan_commutation_pkg::CURVE_LUT[lut_idx];
    wire  [7:0]  lut_hi   = fan_commutation_pkg::CURVE_LUT[lut_idx + 4'h1];
    wire  signed [8:0]  lut_diff = $signed({1'b0, lut_hi}) - $signed({1'b0, lut_lo});
    wire  signed [14:0] lut_prod = lut_diff * $signed({1'b0, in_duty[4:0]});
    wire  signed [9:0]  lut_sum  = $signed({2'b00, lut_lo}) + 10'(lut_prod >>> fan_commutation_pkg::LUT_SHIFT);
    wire  [7:0]  curve_duty = lut_sum[7:0];                                      // R13 R17

    logic        running;
    wire  [8:0]  start_hi = {1'b0, i_start_duty_setting} + {1'b0, fan_commutation_pkg::HYST_DUTY};
    wire         next_running = !i_zero_speed_below_start ? 1'b1 :               // R16
                                ({1'b0, in_duty} > start_hi) ? 1'b1 :
                                (in_duty < i_start_duty_setting) ? 1'b0 : running; // R12
    // Below threshold with zero-speed mode off the curve floor is entry zero
    wire  [7:0]  target_duty = running ? curve_duty : fan_commutation_pkg::DUTY_ZERO;

    // ----------------------------------------------------------------
    // Angle spans scaled from the last timed half turn
    // ----------------------------------------------------------------
    logic [31:0] half_t, seg_cnt, step_cnt;
    logic [6:0]  off_adj;
    logic [3:0]  ramp_idx;
    logic        cz_seen;
    fan_commutation_pkg::comm_state_t state, next_state;

    wire  [7:0]  duty_clamp = (target_duty < fan_commutation_pkg::DUTY_LOW_REF) ?
                              fan_commutation_pkg::DUTY_LOW_REF : target_duty;
    wire  [16:0] interp_k   = (fan_commutation_pkg::DUTY_FULL - duty_clamp) * fan_commutation_pkg::INTERP_RECIP;
    wire  [48:0] interp_p   = half_t * interp_k;
    wire  [31:0] interp_t   = 32'(interp_p >> fan_commutation_pkg::INTERP_SHIFT);
    wire  [31:0] span_on    = (half_t >> fan_commutation_pkg::SHIFT_22P5) + interp_t; // R5
    wire  [31:0] span_off   = (half_t >> fan_commutation_pkg::SHIFT_45) - interp_t;   // R8
    wire  [38:0] off_prod   = (half_t >> fan_commutation_pkg::SHIFT_45) * off_adj;
    wire  [31:0] off_len    = 32'(off_prod >> fan_commutation_pkg::OFF_ADJ_SHIFT);  // R9
    wire  [31:0] step_len   = ((state == fan_commutation_pkg::ST_SOFT_ON) ? span_on : span_off)
                              >> fan_commutation_pkg::RAMP_SHIFT;
    wire         step_done  = (step_cnt >= step_len);
    wire         ramp_done  = step_done && (ramp_idx == fan_commutation_pkg::RAMP_LAST);
    wire         is_driving = (state == fan_commutation_pkg::ST_SOFT_ON) ||
                              (state == fan_commutation_pkg::ST_NORMAL) ||
                              (state == fan_commutation_pkg::ST_SOFT_OFF) ||
                              (state == fan_commutation_pkg::ST_OFF);
    wire         lock_hit   = is_driving && !hall_edge && (seg_cnt >= LOCK_LAST);   // R14
    wire         soft_off_go = (seg_cnt + span_off + off_len) >= half_t;

    // ----------------------------------------------------------------
    // Commutation sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            fan_commutation_pkg::ST_STOP:
                if (running) next_state = fan_commutation_pkg::ST_SOFT_ON;
            fan_commutation_pkg::ST_SOFT_ON:
                if (ramp_done) next_state = fan_commutation_pkg::ST_NORMAL;     // R4
            fan_commutation_pkg::ST_NORMAL:
                if (soft_off_go) next_state = fan_commutation_pkg::ST_SOFT_OFF;
            fan_commutation_pkg::ST_SOFT_OFF:
                if (ramp_done) next_state = fan_commutation_pkg::ST_OFF;        // R7
            fan_commutation_pkg::ST_OFF:
                next_state = state;
            fan_commutation_pkg::ST_LOCKED:
                if (seg_cnt >= RETRY_LAST) next_state = fan_commutation_pkg::ST_SOFT_ON; // R15
            default:
                next_state = fan_commutation_pkg::ST_STOP;
        endcase
        if (is_driving && hall_edge)
            next_state = fan_commutation_pkg::ST_SOFT_ON;                        // R3
        if (lock_hit)
            next_state = fan_commutation_pkg::ST_LOCKED;                         // R15
        if (!running)
            next_state = fan_commutation_pkg::ST_STOP;
    end

    wire new_seg  = (next_state != state) && (state != fan_commutation_pkg::ST_SOFT_ON ||
                    next_state != fan_commutation_pkg::ST_NORMAL);
    wire keep_seg = (next_state == fan_commutation_pkg::ST_NORMAL) ||
                    (next_state == fan_commutation_pkg::ST_SOFT_OFF) ||
                    (next_state == fan_commutation_pkg::ST_OFF);
    wire restart  = hall_edge || (next_state == fan_commutation_pkg::ST_LOCKED && state != next_state) ||
                    (state == fan_commutation_pkg::ST_STOP) || (state == fan_commutation_pkg::ST_LOCKED &&
                    next_state != state);

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            state <= fan_commutation_pkg::ST_STOP;
            running <= 1'b0;
            seg_cnt <= 32'h0; step_cnt <= 32'h0; ramp_idx <= 4'h0;
            half_t <= 32'(START_HALF_CYCLES);
        end
        else
        begin
            state   <= next_state;
            running <= next_running;
            seg_cnt <= (restart && !(keep_seg && !hall_edge)) ? 32'h0 : seg_cnt + 32'h1;
            if (is_driving && hall_edge)
                half_t <= seg_cnt;
            if (new_seg || step_done)
                step_cnt <= 32'h0;
            else
                step_cnt <= step_cnt + 32'h1;
            if (next_state != state)
                ramp_idx <= 4'h0;
            else if (step_done && ramp_idx != fan_commutation_pkg::RAMP_LAST)
                ramp_idx <= ramp_idx + 4'h1;
        end
    end

    // Phase lock: a crossing seen before the Hall fall means the off gap is too long
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            cz_seen <= 1'b0;
            off_adj <= 7'h00;
        end
        else
        begin
            cz_seen <= cz_edge | (cz_seen & ~hall_edge);
            if (hall_fall && is_driving && cz_seen && off_adj != 7'h00)
                off_adj <= off_adj - 7'h01;                                      // R10
            else if (hall_fall && is_driving && !cz_seen && off_adj != fan_commutation_pkg::OFF_ADJ_MAX)
                off_adj <= off_adj + 7'h01;                                      // R10
        end
    end

    // ----------------------------------------------------------------
    // Bridge drive
    // ----------------------------------------------------------------
    wire  [11:0] ramp_up_p = target_duty * ramp_idx;
    wire  [11:0] ramp_dn_p = target_duty * (fan_commutation_pkg::RAMP_LAST - ramp_idx);
    wire  [7:0]  pwm_duty  = (state == fan_commutation_pkg::ST_SOFT_ON)  ? ramp_up_p[11:4] :
                             (state == fan_commutation_pkg::ST_SOFT_OFF) ? ramp_dn_p[11:4] :
                             (state == fan_commutation_pkg::ST_NORMAL)   ? target_duty :   // R6
                             fan_commutation_pkg::DUTY_ZERO;
    logic pwm_sw;

    fan_pwm_gen u_pwm (
        .i_clock        (i_clock),
        .i_rst_n        (i_rst_n),
        .i_duty         (pwm_duty),
        .o_pwm          (pwm_sw),
        .o_period_start ()
    );

    wire switching = (state == fan_commutation_pkg::ST_SOFT_ON) || (state == fan_commutation_pkg::ST_NORMAL) ||
                     (state == fan_commutation_pkg::ST_SOFT_OFF);
    wire locked    = (state == fan_commutation_pkg::ST_LOCKED);
    // Hall high drives leg a; Hall low swaps to leg b
    wire sel_a     = hall_s2;                                                    // R11
    wire drv_high  = switching & pwm_sw;
    wire drv_low   = switching & ~pwm_sw;
    wire idle_low  = is_driving | locked;                                        // R9

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            {o_bridge_output_a_high, o_bridge_output_a_low} <= 2'b00;
            {o_bridge_output_b_high, o_bridge_output_b_low} <= 2'b00;
            o_rotor_locked <= 1'b0;
        end
        else
        begin
            o_bridge_output_a_high <= sel_a & drv_high;
            o_bridge_output_a_low  <= sel_a ? (drv_low | locked) : idle_low;
            o_bridge_output_b_high <= ~sel_a & drv_high;
            o_bridge_output_b_low  <= sel_a ? idle_low : (drv_low | locked);
            o_rotor_locked <= locked;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_curve_breakpoint: assert property ((in_duty[4:0] == 5'h00) |-> // R17
        curve_duty == fan_commutation_pkg::CURVE_LUT[lut_idx]) else $error("Curve misses breakpoint");
    a_normal_second_low: assert property ((state == fan_commutation_pkg::ST_NORMAL && hall_s2) |=> // R6
        o_bridge_output_b_low && !o_bridge_output_b_high) else $error("Second leg not low");
    a_swap_on_low: assert property ((state == fan_commutation_pkg::ST_NORMAL && !hall_s2) |=> // R11
        o_bridge_output_a_low && !o_bridge_output_a_high) else $error("Leg swap missing");
    a_off_hiz_first: assert property ((state == fan_commutation_pkg::ST_OFF && hall_s2) |=> // R9
        !o_bridge_output_a_high && !o_bridge_output_a_low && o_bridge_output_b_low) else $error("Off drive wrong");
    a_normal_target: assert property ((state == fan_commutation_pkg::ST_NORMAL) |-> // R6
        pwm_duty == target_duty) else $error("Normal duty not target");
    a_ramp_up_bound: assert property ((state == fan_commutation_pkg::ST_SOFT_ON) |-> // R4
        pwm_duty <= target_duty && ramp_idx <= fan_commutation_pkg::RAMP_LAST) else $error("Soft-on overshoot");
    a_ramp_down_end: assert property ((state == fan_commutation_pkg::ST_SOFT_OFF && ramp_done && running && // R7
        !hall_edge && !lock_hit) |-> pwm_duty == fan_commutation_pkg::DUTY_ZERO ##1 state == fan_commutation_pkg::ST_OFF)
        else $error("Soft-off end wrong");
    a_start_hyst_hold: assert property ((i_zero_speed_below_start && !running && // R12
        {1'b0, in_duty} <= start_hi) |=> !running) else $error("Started below threshold");
    a_no_stop_mode: assert property (!i_zero_speed_below_start |=> running) // R16
        else $error("Fan stopped with zero-speed off");
    a_lock_window: assert property ((lock_hit && running) |=> state == fan_commutation_pkg::ST_LOCKED ##1 // R14
        o_bridge_output_a_low && o_bridge_output_b_low && o_rotor_locked) else $error("Lock not taken"); // R15

    c_soft_off_seen: cover property (state == fan_commutation_pkg::ST_SOFT_OFF ##1 state == fan_commutation_pkg::ST_OFF);
    c_lock_retry: cover property (state == fan_commutation_pkg::ST_LOCKED ##1 state == fan_commutation_pkg::ST_SOFT_ON);
    c_phase_adjust: cover property (hall_fall && is_driving && cz_seen && off_adj != 7'h00);
endmodule

/* fan_commutation_pkg.sv */
// Purpose : Shared constants for the single-phase fan commutation logic
// Assumes : 100 MHz core clock
// Notes   : Speed curve entries are fixed constants; no software access
package fan_commutation_pkg;

    // ----------------------------------------------------------------
    // Clocking and switching rates
    // ----------------------------------------------------------------
    localparam int CLK_HZ          = 100_000_000;
    localparam int PWM_OUT_HZ      = 26_000;
    localparam int PWM_PERIOD      = CLK_HZ / PWM_OUT_HZ;
    localparam int PWM_IN_MIN_HZ   = 2_000;
    localparam int PWM_IN_MAX_HZ   = 100_000;
    // Input considered static after two slowest input periods
    localparam int IN_TIMEOUT      = 2 * (CLK_HZ / PWM_IN_MIN_HZ);

    // ----------------------------------------------------------------
    // Rotor lock timing
    // ----------------------------------------------------------------
    localparam int LOCK_TIME_MS    = 600;
    localparam int LOCK_MIN_MS     = 450;
    localparam int LOCK_MAX_MS     = 750;
    localparam int RETRY_TIME_MS   = 3600;
    localparam int CYCLES_PER_MS   = CLK_HZ / 1000;
    // Guess at the first half-period before any Hall edge is timed
    localparam int START_HALF      = 1_000_000;

    // ----------------------------------------------------------------
    // Duty figures, 8-bit full scale
    // ----------------------------------------------------------------
    localparam logic [7:0] DUTY_FULL      = 8'hFF;
    localparam logic [7:0] DUTY_ZERO      = 8'h00;
    localparam logic [7:0] DUTY_LOW_REF   = 8'h20;
    localparam logic [7:0] START_DEFAULT  = 8'h20;
    localparam logic [7:0] HYST_DUTY      = 8'h03;

    // ----------------------------------------------------------------
    // Speed curve, nine evenly spaced breakpoints
    // ----------------------------------------------------------------
    localparam int LUT_SHIFT    = 5;
    localparam int LUT_ENTRIES  = 9;
    localparam logic [7:0] CURVE_LUT [0:LUT_ENTRIES-1] =
        '{8'h1F, 8'h1F, 8'h3F, 8'h5F, 8'h7F, 8'h9F, 8'hBF, 8'hDF, 8'hFF};

    // ----------------------------------------------------------------
    // Commutation angles as fractions of a half turn (180 deg)
    // ----------------------------------------------------------------
    localparam int SHIFT_22P5   = 3;
    localparam int SHIFT_45     = 2;
    // 65536/223 : maps (255-duty) over 12.5..100% onto 0..1 in Q16
    localparam logic [8:0] INTERP_RECIP = 9'h126;
    localparam int INTERP_SHIFT = 19;
    localparam int RAMP_STEPS   = 16;
    localparam int RAMP_SHIFT   = 4;
    localparam logic [3:0] RAMP_LAST = 4'hF;
    localparam int OFF_ADJ_SHIFT = 6;
    localparam logic [6:0] OFF_ADJ_MAX = 7'h40;

    typedef enum {
        ST_STOP,
        ST_SOFT_ON,
        ST_NORMAL,
        ST_SOFT_OFF,
        ST_OFF,
        ST_LOCKED
    } comm_state_t;

endpackage

/* fan_pwm_gen.sv */
// Purpose : Fixed-rate bridge PWM generator
// Assumes : Duty is 8-bit, 0 to FF for 0 to 255/256 of the period
// Notes   : Duty latched at period start so a change never makes a runt pulse
`timescale 1ns/10ps
module fan_pwm_gen (
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic [7:0] i_duty,
    output logic            o_pwm,
    output logic            o_period_start
);
    localparam logic [11:0] LAST = 12'(fan_commutation_pkg::PWM_PERIOD - 1);
    localparam logic [11:0] PER  = 12'(fan_commutation_pkg::PWM_PERIOD);

    logic [11:0] cnt;
    logic [7:0]  duty;
    logic [19:0] prod;
    wire         wrap = (cnt == LAST);
    wire  [11:0] on_cnt = prod[19:8];

    assign prod = duty * PER;
    assign o_period_start = (cnt == 12'h000);

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            cnt   <= 12'h000;
            duty  <= 8'h00;
            o_pwm <= 1'b0;
        end
        else
        begin
            cnt   <= wrap ? 12'h000 : cnt + 12'h001;
            if (wrap)
                duty <= i_duty;
            o_pwm <= (cnt < on_cnt);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Independent tally of cycles since the last period start
    logic [11:0] gap;

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            gap <= PER;
        else
            gap <= o_period_start ? 12'h001 : gap + 12'h001;
    end

    a_fixed_period: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R2
        o_period_start |-> gap == PER)
        else $error("Bridge period is not fixed");
    a_period_gap: assert property (@(posedge i_clock) disable iff (!i_rst_n) // R2
        gap <= PER)
        else $error("Bridge period overrun");
    a_zero_duty_low: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (duty == 8'h00) |=> !o_pwm)
        else $error("Output pulses at zero duty");
endmodule

/* fan_host_model.sv */
// Purpose: Host speed PWM and rotor model
// Assumes: Driven on the falling clock edge
// Notes  : A stalled rotor holds its Hall level
`timescale 1ns/10ps
module fan_host_model #(parameter int HALF = 12000) (
    input  wire logic        i_clock,
    input  wire logic        i_spin,
    input  wire logic [15:0] i_high,
    input  wire logic [15:0] i_period,
    output logic             o_speed_pwm,
    output logic             o_hall,
    output logic             o_current_zero
);
    int pcnt = 0;
    int hcnt = 0;
    initial
    begin
        o_speed_pwm = 1'b0;
        o_hall = 1'b0;
        o_current_zero = 1'b0;
    end
    always @(negedge i_clock)
    begin
        pcnt <= (pcnt + 1 >= int'(i_period)) ? 0 : pcnt + 1;
        o_speed_pwm <= pcnt < int'(i_high);
        if (i_spin)
        begin
            hcnt <= (hcnt + 1 >= HALF) ? 0 : hcnt + 1;
            o_hall <= (hcnt + 1 >= HALF) ? ~o_hall : o_hall;
            o_current_zero <= hcnt >= HALF / 2;
        end
    end
endmodule

/* single_phase_fan_commutation_test.sv */
// Purpose: Self-checking bench for the fan commutation block
// Assumes: Shortened lock, retry and start counts
// Notes  : Gate pattern packed as {a_high, a_low, b_high, b_low}
`timescale 1ns/10ps
module single_phase_fan_commutation_test;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        spin = 1'b0;
    logic        zero_mode = 1'b1;
    logic [7:0]  start_set = 8'h20;
    logic [15:0] high = 16'h0000;
    logic [15:0] period = 16'h03E8;
    logic        pwm, hall, cz, ah, al, bh, bl, locked;
    logic [7:0]  duty;
    logic [3:0]  gates;
    int          err_count = 0;
    int          check_count = 0;
    int          cycles = 0;
    longint      last_rise = 0;
    assign gates = {ah, al, bh, bl};
    initial
    begin
        forever #5 clock = ~clock;
    end
    fan_host_model fan_host_model_i (.i_clock(clock), .i_spin(spin), .i_high(high), .i_period(period),
        .o_speed_pwm(pwm), .o_hall(hall), .o_current_zero(cz));
    fan_commutation #(.IN_TIMEOUT_CYCLES(12000), .LOCK_CYCLES(15000), .RETRY_CYCLES(5000),
        .START_HALF_CYCLES(12000)) fan_commutation_i (.i_clock(clock), .i_rst_n(rst_n),
        .i_speed_pwm(pwm), .i_hall(hall), .i_current_zero(cz), .i_zero_speed_below_start(zero_mode),
        .i_start_duty_setting(start_set), .o_bridge_output_a_high(ah), .o_bridge_output_a_low(al),
        .o_bridge_output_b_high(bh), .o_bridge_output_b_low(bl), .o_rotor_locked(locked),
        .o_input_duty(duty));
    task automatic end_of_test;
        if (err_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic set_pwm(input logic [15:0] h, input logic [15:0] p);
        high = h;
        period = p;
        run(4 * int'(p));
    endtask
    task automatic watch(input int n, output logic [3:0] seen, output logic [3:0] held);
        seen = 4'h0;
        held = 4'hF;
        repeat (n)
        begin
            @(negedge clock);
            seen |= gates;
            held &= gates;
        end
    endtask
    // Interval between leg a high-side pulses must be a whole number of bridge periods
    always @(posedge ah)
    begin
        if (last_rise > 0 && ($time - last_rise) < 80000)
            chk("pwm_gap", 8'h00, 8'((($time - last_rise) / 10) % 3846));
        last_rise = $time;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 100000)
        begin
            err_count++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_stop;
        logic [3:0] seen, held;
        set_pwm(16'h0064, 16'h03E8);
        chk("input_duty", 8'h19, duty);
        watch(1000, seen, held);
        chk("stop_gates", 8'h00, {4'h0, seen});
        set_pwm(16'h0085, 16'h03E8);
        chk("input_duty", 8'h22, duty);
        watch(1000, seen, held);
        chk("band_gates", 8'h00, {4'h0, seen});
        start_set = 8'h10;
        watch(100, seen, held);
        chk("low_start_gates", 8'h01, {7'h0, |seen});
        start_set = 8'h40;
        run(5);
        watch(10, seen, held);
        chk("restop_gates", 8'h00, {4'h0, seen});
    endtask
    task automatic t_free;
        logic [3:0] seen, held;
        zero_mode = 1'b0;
        run(100);
        watch(500, seen, held);
        chk("free_gates", 8'h01, {7'h0, |seen});
    endtask
    task automatic t_run;
        logic [3:0] seen, held;
        spin = 1'b1;
        set_pwm(16'h09C4, 16'h1388);
        chk("input_duty", 8'h80, duty);
        @(posedge hall);
        run(20);
        watch(11000, seen, held);
        chk("leg_a", 8'h81, {seen & 4'hA, held & 4'h1});
        @(negedge hall);
        run(20);
        watch(11000, seen, held);
        chk("leg_b", 8'h24, {seen & 4'hA, held & 4'h4});
    endtask
    task automatic t_lock;
        spin = 1'b0;
        for (int i = 0; i < 20000 && locked !== 1'b1; i++)
            run(1);
        run(1);
        chk("locked", 8'h01, {7'h0, locked});
        chk("lock_gates", 8'h05, {4'h0, gates});
        for (int i = 0; i < 5100 && locked !== 1'b0; i++)
            run(1);
        chk("retry", 8'h00, {7'h0, locked});
    endtask
    initial
    begin
        run(6);
        chk("reset_gates", 8'h00, {4'h0, gates});
        rst_n = 1'b1;
        t_stop();
        t_free();
        t_run();
        t_lock();
        end_of_test();
    end
endmodule
